/* File: cgt_params.svh */
`ifndef CGT_PARAMS_SVH
`define CGT_PARAMS_SVH

// Register indices on the plain port
`define CGT_ADDR_W          4
`define CGT_A_LOW_COUNT     4'h0
`define CGT_A_HIGH_COUNT    4'h1
`define CGT_A_HOLDING       4'h2
`define CGT_A_PERIOD_LOW    4'h3
`define CGT_A_PERIOD_HIGH   4'h4
`define CGT_A_LOW_CTRL      4'h5
`define CGT_A_HIGH_CTRL     4'h6
`define CGT_A_IRQ_STATUS    4'h7
`define CGT_A_IRQ_MASK      4'h8

// Control register field positions
`define CGT_B_TIMER_ON      15
`define CGT_B_STOP_IN_IDLE  13
`define CGT_B_GATE_ACCUM    6
`define CGT_B_PRESCALE_HI   5
`define CGT_B_PRESCALE_LO   4
`define CGT_B_MODE_32       3
`define CGT_B_EXT_SYNC      2
`define CGT_B_CLK_SOURCE    1

// Implemented control bits; the rest read as zero
`define CGT_CTRL_MASK       16'ha07e

// Reset values
`define CGT_RST_COUNT       16'h0000
`define CGT_RST_PERIOD      16'hffff
`define CGT_RST_CTRL        16'h0000
`define CGT_RST_IRQ         2'h0

// Prescaler terminal masks for 1:1, 1:8, 1:64, 1:256
`define CGT_PS_MASK_1       8'h00
`define CGT_PS_MASK_8       8'h07
`define CGT_PS_MASK_64      8'h3f
`define CGT_PS_MASK_256     8'hff

`endif

/* File: cgt_pkg.sv */
package cgt_pkg;

   // Decoded control register of one timer
   typedef struct packed {
      logic       timer_on;
      logic       stop_in_idle;
      logic       gate_accum_enable;
      logic [1:0] clock_prescale_select;
      logic       mode_32;
      logic       external_sync_select;
      logic       clock_source_select;
   } cgt_ctrl_type;

   // Register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } cgt_bus_type;

endpackage : cgt_pkg

/* File: cgt_sync2.sv */
`timescale 1ns/100ps
module cgt_sync2
   import cgt_pkg::*;
#(
   parameter int WIDTH = 2
)
(
   input  wire logic             i_clk,   // Instruction clock
   input  wire logic             i_rst_b, // Async reset, active low
   input  wire logic [WIDTH-1:0] i_async, // Pin levels
   output logic      [WIDTH-1:0] o_sync   // Synchronised levels
);

   logic [WIDTH-1:0] meta_q;

   // Two-stage synchroniser
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta_q <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : cgt_sync2

/* File: cgt_prescaler.sv */
`timescale 1ns/100ps
`include "cgt_params.svh"
module cgt_prescaler
   import cgt_pkg::*;
#(
   parameter int CNT_W    = 8,
   parameter bit SYNC_OUT = 1'b0
)
(
   input  wire logic       i_clk,   // Instruction clock
   input  wire logic       i_rst_b, // Async reset, active low
   input  wire logic       i_tick,  // Input clock event, halted when off
   input  wire logic       i_clear, // Clear the divider
   input  wire logic [1:0] i_sel,   // Division select
   output logic            o_pulse  // Divided clock event
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] mask;
   logic             hit;
   logic             pulse_q;

   generate
      if (CNT_W < 8)
      begin : g_chk
         $error("cgt_prescaler: CNT_W must be at least 8");
      end
   endgenerate

   // Terminal count select
   assign mask = (i_sel == 2'h0) ? CNT_W'(`CGT_PS_MASK_1)  :
                 (i_sel == 2'h1) ? CNT_W'(`CGT_PS_MASK_8)  :
                 (i_sel == 2'h2) ? CNT_W'(`CGT_PS_MASK_64) :
                                   CNT_W'(`CGT_PS_MASK_256);
   assign hit  = i_tick & ((cnt_q & mask) == mask);

   // Divider counter, frozen while no ticks arrive
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cnt_q <= '0;
      else if (i_clear)
         cnt_q <= '0;
      else if (i_tick)
         cnt_q <= cnt_q + CNT_W'(1);
   end

   // Optional resynchronised output stage
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         pulse_q <= 1'b0;
      else
         pulse_q <= hit & ~i_clear;
   end

   assign o_pulse = SYNC_OUT ? pulse_q : hit;

endmodule : cgt_prescaler

/* File: cgt_timer.sv */
`timescale 1ns/100ps
`include "cgt_params.svh"
module cgt_timer
   import cgt_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int PS_W  = 8
)
(
   input  wire logic        i_clk,           // Instruction clock
   input  wire logic        i_rst_b,         // Async reset, active low
   input  cgt_bus_type      i_bus,           // Register request
   output logic [WIDTH-1:0] o_rdata,         // Read data, next cycle
   input  wire logic        i_lower_pin,     // Lower clock or gate pin
   input  wire logic        i_upper_pin,     // Upper clock or gate pin
   input  wire logic        i_cpu_idle,      // CPU in Idle
   input  wire logic        i_cpu_sleep,     // CPU in Sleep
   output logic             o_irq            // Level interrupt
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   ////////////////////////////////////////////////////////////////////////

   generate
      if (WIDTH != 16)
      begin : g_chk_w
         $error("cgt_timer: WIDTH must be 16");
      end
      if (PS_W < 8)
      begin : g_chk_ps
         $error("cgt_timer: PS_W must be at least 8");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////

   logic [1:0][WIDTH-1:0] cnt_q;
   logic [1:0][WIDTH-1:0] cnt_d;
   logic [1:0][WIDTH-1:0] per_q;
   logic [1:0][WIDTH-1:0] ctrl_q;
   logic [WIDTH-1:0]      hold_q;
   logic [1:0]            irq_st_q;
   logic [1:0]            irq_st_d;
   logic [1:0]            irq_mask_q;
   logic [WIDTH-1:0]      rdata_d;
   logic [1:0]            pin_sync;
   logic [1:0]            pin_prev_q;
   logic [1:0]            pin_rise;
   cgt_ctrl_type [1:0]    ctrl;
   cgt_ctrl_type [1:0]    eff;
   logic                  mode32;
   logic [1:0]            pin_lvl;
   logic [1:0]            pin_edge;
   logic [1:0]            src_tick;
   logic [1:0]            run;
   logic [1:0]            ps_tick;
   logic [1:0]            ps_clear;
   logic [1:0]            adv;
   logic [1:0]            match16;
   logic                  match32;
   logic [1:0]            irq_set;
   logic [2*WIDTH-1:0]    cnt32;
   logic [2*WIDTH-1:0]    per32;
   logic [2*WIDTH-1:0]    cnt32_inc;
   logic                  wr_lo;
   logic                  wr_hi;
   logic                  wr_hold;
   logic                  wr_plo;
   logic                  wr_phi;
   logic                  wr_clo;
   logic                  wr_chi;
   logic                  wr_ist;
   logic                  wr_imask;
   logic                  rd_lo;
   logic [1:0]            wr_ctrl;
   logic [1:0]            wr_cnt;
   logic [1:0]            on_fall;

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   ////////////////////////////////////////////////////////////////////////

   // Write strobes per register
   assign wr_lo    = i_bus.wr & (i_bus.addr == `CGT_A_LOW_COUNT);
   assign wr_hi    = i_bus.wr & (i_bus.addr == `CGT_A_HIGH_COUNT);
   assign wr_hold  = i_bus.wr & (i_bus.addr == `CGT_A_HOLDING);
   assign wr_plo   = i_bus.wr & (i_bus.addr == `CGT_A_PERIOD_LOW);
   assign wr_phi   = i_bus.wr & (i_bus.addr == `CGT_A_PERIOD_HIGH);
   assign wr_clo   = i_bus.wr & (i_bus.addr == `CGT_A_LOW_CTRL);
   assign wr_chi   = i_bus.wr & (i_bus.addr == `CGT_A_HIGH_CTRL);
   assign wr_ist   = i_bus.wr & (i_bus.addr == `CGT_A_IRQ_STATUS);
   assign wr_imask = i_bus.wr & (i_bus.addr == `CGT_A_IRQ_MASK);
   assign rd_lo    = i_bus.rd & (i_bus.addr == `CGT_A_LOW_COUNT);
   assign wr_ctrl  = {wr_chi, wr_clo};
   assign wr_cnt   = {wr_hi, wr_lo};

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   ////////////////////////////////////////////////////////////////////////

   cgt_sync2 #(
      .WIDTH   (2)
   ) u_pin_sync (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_async ({i_upper_pin, i_lower_pin}),
      .o_sync  (pin_sync)
   );

   // Edge history of synchronised pins
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         pin_prev_q <= 2'h0;
      else
         pin_prev_q <= pin_sync;
   end

   assign pin_rise = pin_sync & ~pin_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // Control decode and clock selection
   ////////////////////////////////////////////////////////////////////////

   // Upper timer borrows lower controls and pin in 32-bit mode
   assign mode32 = ctrl[0].mode_32;
   assign eff[0] = ctrl[0];
   assign eff[1] = mode32 ? ctrl[0] : ctrl[1];
   assign pin_lvl  = {mode32 ? pin_sync[0] : pin_sync[1], pin_sync[0]};
   assign pin_edge = {mode32 ? pin_rise[0] : pin_rise[1], pin_rise[0]};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_tmr
         // Field unpacking
         assign ctrl[g].timer_on             = ctrl_q[g][`CGT_B_TIMER_ON];
         assign ctrl[g].stop_in_idle         = ctrl_q[g][`CGT_B_STOP_IN_IDLE];
         assign ctrl[g].gate_accum_enable    = ctrl_q[g][`CGT_B_GATE_ACCUM];
         assign ctrl[g].clock_prescale_select =
            ctrl_q[g][`CGT_B_PRESCALE_HI:`CGT_B_PRESCALE_LO];
         assign ctrl[g].mode_32              = ctrl_q[g][`CGT_B_MODE_32];
         assign ctrl[g].external_sync_select = ctrl_q[g][`CGT_B_EXT_SYNC];
         assign ctrl[g].clock_source_select  = ctrl_q[g][`CGT_B_CLK_SOURCE];

         // Source: external edge, gated cycle, or every cycle
         assign src_tick[g] = eff[g].clock_source_select ? pin_edge[g] :
                              eff[g].gate_accum_enable   ? pin_lvl[g]  :
                              1'b1;

         // Run only when on, not idle-stopped, and not asleep unless clocked from an unsynchronised external pin
         assign run[g] = eff[g].timer_on
                       & ~(i_cpu_idle & eff[g].stop_in_idle)
                       & (~i_cpu_sleep
                          | (eff[g].clock_source_select
                             & ~eff[g].external_sync_select));

         assign ps_tick[g] = run[g] & src_tick[g];

         // Clear on count write or timer_on being cleared
         assign on_fall[g]  = wr_ctrl[g] & ctrl[g].timer_on
                            & ~i_bus.wdata[`CGT_B_TIMER_ON];
         assign ps_clear[g] = wr_cnt[g] | on_fall[g];

         cgt_prescaler #(
            .CNT_W    (PS_W),
            .SYNC_OUT (g == 0)
         ) u_ps (
            .i_clk    (i_clk),
            .i_rst_b  (i_rst_b),
            .i_tick   (ps_tick[g]),
            .i_clear  (ps_clear[g]),
            .i_sel    (eff[g].clock_prescale_select),
            .o_pulse  (adv[g])
         );

         assign match16[g] = (cnt_q[g] == per_q[g]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Counting
   ////////////////////////////////////////////////////////////////////////

   // Pair joined as one wide count
   assign cnt32     = {cnt_q[1], cnt_q[0]};
   assign per32     = {per_q[1], per_q[0]};
   assign match32   = (cnt32 == per32);
   assign cnt32_inc = cnt32 + (2*WIDTH)'(1);

   // Next count: advance, wrap on match, then software loads win
   always_comb
   begin
      cnt_d   = cnt_q;
      irq_set = 2'h0;
      if (mode32)
      begin
         if (adv[0])
         begin
            if (match32)
            begin
               cnt_d[0]   = `CGT_RST_COUNT;
               cnt_d[1]   = `CGT_RST_COUNT;
               irq_set[1] = 1'b1;
            end
            else
            begin
               cnt_d[0] = cnt32_inc[WIDTH-1:0];
               cnt_d[1] = cnt32_inc[2*WIDTH-1:WIDTH];
            end
         end
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (adv[i])
            begin
               if (match16[i])
               begin
                  cnt_d[i]   = `CGT_RST_COUNT;
                  irq_set[i] = 1'b1;
               end
               else
                  cnt_d[i] = cnt_q[i] + WIDTH'(1);
            end
         end
      end
      if (wr_lo)
      begin
         cnt_d[0] = i_bus.wdata;
         if (mode32)
            cnt_d[1] = hold_q;
      end
      if (wr_hi)
         cnt_d[1] = i_bus.wdata;
   end

   // Count registers; control writes do not touch them
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cnt_q <= {2{`CGT_RST_COUNT}};
      else
         cnt_q <= cnt_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Holding, period and control registers
   ////////////////////////////////////////////////////////////////////////

   // Holding register: read capture or direct write
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         hold_q <= `CGT_RST_COUNT;
      else if (rd_lo)
         hold_q <= cnt_q[1];
      else if (wr_hold)
         hold_q <= i_bus.wdata;
   end

   // Period and control storage
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         per_q  <= {2{`CGT_RST_PERIOD}};
         ctrl_q <= {2{`CGT_RST_CTRL}};
      end
      else
      begin
         if (wr_plo)
            per_q[0] <= i_bus.wdata;
         if (wr_phi)
            per_q[1] <= i_bus.wdata;
         if (wr_clo)
            ctrl_q[0] <= i_bus.wdata & `CGT_CTRL_MASK;
         if (wr_chi)
            ctrl_q[1] <= i_bus.wdata & `CGT_CTRL_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts
   ////////////////////////////////////////////////////////////////////////

   // Sticky flags: write one clears, a new match wins
   assign irq_st_d = irq_set
                   | (irq_st_q & ~(wr_ist ? i_bus.wdata[1:0] : 2'h0));

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         irq_st_q   <= `CGT_RST_IRQ;
         irq_mask_q <= `CGT_RST_IRQ;
      end
      else
      begin
         irq_st_q <= irq_st_d;
         if (wr_imask)
            irq_mask_q <= i_bus.wdata[1:0];
      end
   end

   assign o_irq = |(irq_st_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////
   // Read path
   ////////////////////////////////////////////////////////////////////////

   // Read data select, unmapped reads give zero
   always_comb
   begin
      case (i_bus.addr)
         `CGT_A_LOW_COUNT:   rdata_d = cnt_q[0];
         `CGT_A_HIGH_COUNT:  rdata_d = cnt_q[1];
         `CGT_A_HOLDING:     rdata_d = hold_q;
         `CGT_A_PERIOD_LOW:  rdata_d = per_q[0];
         `CGT_A_PERIOD_HIGH: rdata_d = per_q[1];
         `CGT_A_LOW_CTRL:    rdata_d = ctrl_q[0];
         `CGT_A_HIGH_CTRL:   rdata_d = ctrl_q[1];
         `CGT_A_IRQ_STATUS:  rdata_d = {{(WIDTH-2){1'b0}}, irq_st_q};
         `CGT_A_IRQ_MASK:    rdata_d = {{(WIDTH-2){1'b0}}, irq_mask_q};
         default:            rdata_d = '0;
      endcase
   end

   // Read data register, valid the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_rdata <= '0;
      else if (i_bus.rd)
         o_rdata <= rdata_d;
      else
         o_rdata <= '0;
   end

endmodule : cgt_timer

/* File: cgt_pin_source.sv */
`timescale 1ns/100ps
module cgt_pin_source
(
   input  wire logic i_clk,       // Instruction clock
   output logic      o_lower_pin, // Lower clock or gate pin
   output logic      o_upper_pin  // Upper clock or gate pin
);
   // Both pins rest low outside bursts
   initial
   begin
      o_lower_pin = 1'b0;
      o_upper_pin = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Set one pin level just after a rising edge
   task automatic put(input bit up, input bit v);
      @(posedge i_clk);
      if (up)
         o_upper_pin <= v;
      else
         o_lower_pin <= v;
   endtask : put
   // Burst of n clock edges, each level held hc cycles for the synchroniser
   task automatic pulses(input bit up, input int n, input int hc);
      repeat (n)
      begin
         put(up, 1'b1);
         repeat (hc - 1) @(posedge i_clk);
         put(up, 1'b0);
         repeat (hc - 1) @(posedge i_clk);
      end
   endtask : pulses
endmodule : cgt_pin_source

/* File: cgt_timer_monitor.sv */
`timescale 1ns/100ps
`include "cgt_params.svh"
module cgt_timer_monitor
   import cgt_pkg::*;
(
   input  wire logic        i_clk,       // Instruction clock
   input  wire logic        i_rst_b,     // Async reset, active low
   input  cgt_bus_type      i_bus,       // Register request
   input  wire logic [15:0] o_rdata,     // Read data
   input  wire logic        i_lower_pin, // Lower pin
   input  wire logic        i_upper_pin, // Upper pin
   input  wire logic        i_cpu_idle,  // Idle level
   input  wire logic        i_cpu_sleep, // Sleep level
   input  wire logic        o_irq        // Interrupt
);
   logic [1:0]  mask_q;
   logic [15:0] plo_q;
   logic [15:0] lctl_q;
   logic [15:0] hold_q;
   logic        hv_q;
   logic [15:0] ref_q;
   logic        ok_q;
   logic        rdq;
   logic [2:0]  fz_n;
   ////////////////////////////////////////////////////////////////////////
   // Request decode and lower timer freeze condition
   wire         wr_a = i_bus.wr;
   wire         rd_a = i_bus.rd;
   wire [3:0]   ad   = i_bus.addr;
   wire [15:0]  wd   = i_bus.wdata;
   wire         frz  = !lctl_q[15] || (i_cpu_idle && lctl_q[13])
                       || (i_cpu_sleep && !(lctl_q[1] && !lctl_q[2]));
   wire         settled = fz_n == 3'h7;
   // Shadow of registers and last known lower count
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         mask_q <= 2'h0;
         plo_q  <= 16'hffff;
         lctl_q <= 16'h0000;
         hold_q <= 16'h0000;
         hv_q   <= 1'b1;
         ref_q  <= 16'h0000;
         ok_q   <= 1'b0;
         rdq    <= 1'b0;
         fz_n   <= 3'h0;
      end
      else
      begin
         if (wr_a && ad == 4'h8) mask_q <= wd[1:0];
         if (wr_a && ad == 4'h3) plo_q <= wd;
         if (wr_a && ad == 4'h5) lctl_q <= wd;
         if (wr_a && ad == 4'h2) hold_q <= wd;
         hv_q <= (wr_a && ad == 4'h2) || (hv_q && !(rd_a && ad == 4'h0));
         rdq  <= rd_a && ad == 4'h0;
         if (wr_a && ad == 4'h0) ref_q <= wd;
         else if (rdq) ref_q <= o_rdata;
         ok_q <= settled && (ok_q || (wr_a && ad == 4'h0) || rdq);
         fz_n <= !frz ? 3'h0 : settled ? fz_n : fz_n + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_rdata_quiet: assert property (!$past(rd_a) |-> o_rdata == 16'h0000)
      else $error("read data without a read");
   a_irq_masked: assert property (mask_q == 2'h0 |-> !o_irq)
      else $error("interrupt with all sources masked");
   a_irq_matches: assert property ($past(rd_a && ad == 4'h7)
      |-> $past(o_irq) == |(o_rdata[1:0] & $past(mask_q)))
      else $error("interrupt level disagrees with status");
   a_mask_readback: assert property ($past(rd_a && ad == 4'h8)
      |-> o_rdata == {14'h0000, $past(mask_q)})
      else $error("mask read back wrong");
   a_period_readback: assert property ($past(rd_a && ad == 4'h3)
      |-> o_rdata == $past(plo_q))
      else $error("period read back wrong");
   a_hold_readback: assert property (rd_a && ad == 4'h2 && hv_q
      |=> o_rdata == $past(hold_q))
      else $error("holding read back wrong");
   a_ctrl_reserved: assert property ($past(rd_a && ad inside {4'h5, 4'h6})
      |-> (o_rdata & ~`CGT_CTRL_MASK) == 16'h0000)
      else $error("reserved control bits not zero");
   a_count_held: assert property (rd_a && ad == 4'h0
      && ok_q && settled |=> o_rdata == ref_q)
      else $error("stopped lower count moved");
   c_wide_read: cover property (rd_a && ad == 4'h0 ##[1:4] rd_a && ad == 4'h2);
   c_irq_rise: cover property ($rose(o_irq));
   c_idle_hold: cover property (i_cpu_idle && ok_q && settled);
endmodule : cgt_timer_monitor

bind cgt_timer cgt_timer_monitor mon
(
   .i_clk       (i_clk),
   .i_rst_b     (i_rst_b),
   .i_bus       (i_bus),
   .o_rdata     (o_rdata),
   .i_lower_pin (i_lower_pin),
   .i_upper_pin (i_upper_pin),
   .i_cpu_idle  (i_cpu_idle),
   .i_cpu_sleep (i_cpu_sleep),
   .o_irq       (o_irq)
);

/* File: cgt_timer_tb.sv */
`timescale 1ns/100ps
module cgt_timer_tb
   import cgt_pkg::*;
;
   logic        i_clk = 1'b0;
   logic        i_rst_b;
   cgt_bus_type bus;
   logic [15:0] rdata;
   logic        lpin;
   logic        upin;
   logic        idle;
   logic        sleep;
   logic        irq;
   int          failures = 0;
   int          checked = 0;
   int          cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   cgt_timer dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(bus),
      .o_rdata(rdata), .i_lower_pin(lpin), .i_upper_pin(upin),
      .i_cpu_idle(idle), .i_cpu_sleep(sleep), .o_irq(irq));
   cgt_pin_source src (.i_clk(i_clk), .o_lower_pin(lpin),
      .o_upper_pin(upin));
   // Clock and hang guard
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk);
      bus <= '0;
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk);
      bus <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge i_clk);
      bus <= '0;
      @(negedge i_clk);
      chk(rdata, e);
   endtask : rdc
   task automatic irqc(input logic e);
      @(negedge i_clk);
      chk({15'h0000, irq}, {15'h0000, e});
   endtask : irqc
   ////////////////////////////////////////////////////////////////////////
   // Reset values, unmapped index included
   task automatic t_reset;
      for (int a = 0; a < 10; a++)
         rdc(a[3:0], (a == 3 || a == 4) ? 16'hffff : 16'h0000);
      $display("reset test done");
   endtask : t_reset
   // Count loads, control writes, prescaler ratios, lower latency
   task automatic t_count;
      int d;
      wr(4'h0, 16'h1234);
      wr(4'h5, 16'h0030);
      rdc(4'h0, 16'h1234);
      for (int p = 0; p < 4; p++)
      begin
         d = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
         wr(4'h1, 16'h0000);
         wr(4'h6, 16'h8000 | {10'h000, p[1:0], 4'h0});
         cyc(3 * d + d / 2 - 2);
         wr(4'h6, 16'h0000);
         rdc(4'h1, 16'h0003);
      end
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h8000);
      cyc(1);
      wr(4'h5, 16'h0000);
      rdc(4'h0, 16'h0002);
      $display("count test done");
   endtask : t_count
   // Period match flag, mask and clear
   task automatic t_irq;
      wr(4'h4, 16'h0004);
      wr(4'h8, 16'h0002);
      wr(4'h6, 16'h8000);
      cyc(20);
      wr(4'h6, 16'h0000);
      irqc(1'b1);
      rdc(4'h7, 16'h0002);
      wr(4'h8, 16'h0000);
      irqc(1'b0);
      wr(4'h8, 16'h0002);
      irqc(1'b1);
      wr(4'h7, 16'h0002);
      irqc(1'b0);
      $display("irq test done");
   endtask : t_irq
   // Cascaded pair: coherent access, wrap at combined period
   task automatic t_wide;
      wr(4'h5, 16'h0008);
      wr(4'h2, 16'h0001);
      rdc(4'h2, 16'h0001);
      wr(4'h0, 16'hfffe);
      rdc(4'h1, 16'h0001);
      wr(4'h2, 16'h5a5a);
      rdc(4'h0, 16'hfffe);
      rdc(4'h2, 16'h0001);
      wr(4'h4, 16'h0001);
      wr(4'h6, 16'h8030);
      wr(4'h5, 16'h8008);
      cyc(1);
      wr(4'h5, 16'h0008);
      wr(4'h6, 16'h0000);
      rdc(4'h0, 16'h0000);
      rdc(4'h2, 16'h0000);
      rdc(4'h7, 16'h0002);
      wr(4'h7, 16'h0003);
      $display("wide test done");
   endtask : t_wide
   // Gated accumulation, then idle with and without stop
   task automatic t_gate;
      wr(4'h5, 16'h0000);
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h8040);
      cyc(4);
      src.put(1'b0, 1'b1);
      cyc(9);
      src.put(1'b0, 1'b0);
      cyc(8);
      rdc(4'h0, 16'h000a);
      wr(4'h5, 16'h0000);
      @(posedge i_clk);
      idle <= 1'b1;
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'ha000);
      cyc(10);
      rdc(4'h0, 16'h0000);
      wr(4'h5, 16'h8000);
      cyc(1);
      wr(4'h5, 16'h0000);
      rdc(4'h0, 16'h0002);
      @(posedge i_clk);
      idle <= 1'b0;
      $display("gate test done");
   endtask : t_gate
   // Sleep: async external clock counts and wraps, synced one stops
   task automatic t_sleep;
      wr(4'h4, 16'h0002);
      wr(4'h1, 16'h0000);
      wr(4'h6, 16'h8002);
      sleep <= 1'b1;
      src.pulses(1'b1, 5, 3);
      cyc(8);
      rdc(4'h1, 16'h0002);
      rdc(4'h7, 16'h0002);
      wr(4'h6, 16'h8006);
      src.pulses(1'b1, 3, 3);
      cyc(8);
      rdc(4'h1, 16'h0002);
      @(posedge i_clk);
      sleep <= 1'b0;
      wr(4'h6, 16'h0000);
      wr(4'h7, 16'h0003);
      $display("sleep test done");
   endtask : t_sleep
   // Cascaded synchronous counter on the lower pin, idle stop
   task automatic t_sync;
      wr(4'h2, 16'h0000);
      wr(4'h0, 16'h0000);
      wr(4'h5, 16'h800e);
      src.pulses(1'b0, 4, 3);
      cyc(8);
      rdc(4'h0, 16'h0004);
      @(posedge i_clk);
      idle <= 1'b1;
      wr(4'h5, 16'ha00e);
      src.pulses(1'b0, 3, 3);
      cyc(8);
      rdc(4'h0, 16'h0004);
      @(posedge i_clk);
      idle <= 1'b0;
      wr(4'h5, 16'h0000);
      $display("sync test done");
   endtask : t_sync
   ////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // Main sequence
   initial
   begin
      i_rst_b = 1'b0;
      bus = '0;
      idle = 1'b0;
      sleep = 1'b0;
      repeat (20) @(posedge i_clk);
      i_rst_b <= 1'b1;
      t_reset();
      t_count();
      t_irq();
      t_wide();
      t_gate();
      t_sleep();
      t_sync();
      results();
   end
endmodule : cgt_timer_tb
